// ---- szac_pkg.sv ----
// Shared constants and carrier types for the secure zone access control block.
// Assumes a bit-addressed memory of 1568 cells and a one-request-per-cycle caller.
package szac_pkg;

   localparam int              MEM_BITS   = 1568;
   localparam int              ADDR_W     = 11;
   localparam int              WORD_LSB_W = 4;
   localparam logic [3:0]      WORD_FIRST = 4'h0;
   localparam logic [3:0]      WORD_LAST  = 4'hF;

   // Zone boundaries, inclusive bit addresses.
   localparam logic [10:0] FAB_LO       = 11'h000;   // 0
   localparam logic [10:0] FAB_HI       = 11'h00F;   // 15
   localparam logic [10:0] ISS_LO       = 11'h010;   // 16
   localparam logic [10:0] ISS_HI       = 11'h04F;   // 79
   localparam logic [10:0] SC_LO        = 11'h050;   // 80
   localparam logic [10:0] SC_HI        = 11'h05F;   // 95
   localparam logic [10:0] TALLY_LO     = 11'h060;   // 96
   localparam logic [10:0] TALLY_ACT_HI = 11'h067;   // 103
   localparam logic [10:0] TALLY_HI     = 11'h06F;   // 111
   localparam logic [10:0] CGA_LO       = 11'h070;   // 112
   localparam logic [10:0] CGA_HI       = 11'h0AF;   // 175
   localparam logic [10:0] APPA_LO      = 11'h0B0;   // 176
   localparam logic [10:0] APPA_HI      = 11'h2AF;   // 687
   localparam logic [10:0] KEYA_LO      = 11'h2B0;   // 688
   localparam logic [10:0] KEYA_HI      = 11'h2DF;   // 735
   localparam logic [10:0] APPB_LO      = 11'h2E0;   // 736
   localparam logic [10:0] APPB_HI      = 11'h4DF;   // 1247
   localparam logic [10:0] KEYB_LO      = 11'h4E0;   // 1248
   localparam logic [10:0] KEYB_HI      = 11'h4FF;   // 1279
   localparam logic [10:0] EC_LO        = 11'h500;   // 1280
   localparam logic [10:0] EC_HI        = 11'h57F;   // 1407
   localparam logic [10:0] ELIM_FUSE    = 11'h5F9;   // 1529
   localparam logic [10:0] ISSF_LO      = 11'h610;   // 1552
   localparam logic [10:0] ISSF_HI      = 11'h61F;   // 1567

   // Lock bits inside the application areas.
   localparam logic [10:0] APPA_WLOCK   = 11'h0B0;   // 176
   localparam logic [10:0] APPA_RLOCK   = 11'h0B1;   // 177
   localparam logic [10:0] APPB_WLOCK   = 11'h2E0;   // 736
   localparam logic [10:0] APPB_RLOCK   = 11'h2E1;   // 737

   typedef enum logic [1:0] {
      OP_READ,
      OP_WRITE,
      OP_ERASE,
      OP_COMPARE
   } szac_op_e;

   typedef enum logic [1:0] {
      CMP_IDLE,
      CMP_SC,
      CMP_KEY_A,
      CMP_KEY_B
   } szac_cmp_e;

   typedef struct packed {
      logic              valid;
      szac_op_e          op;
      logic [10:0]       addr;
      logic              cmp_bit;
   } szac_req_s;

   typedef struct packed {
      logic security_valid_flag;
      logic app_a_erase_ok;
      logic app_b_erase_ok;
      logic level2;
      logic tally_locked;
      logic erase_limit_spent;
   } szac_stat_s;

endpackage

// ---- szac_core.sv ----
// Access control and storage for a bit-serial secure card memory.
// Assumes requests arrive synchronous to sys_clk_in, one at most per cycle.
`timescale 1ns/1ps

module szac_core
   import szac_pkg::*;
#(
   parameter logic [15:0] FAB_CODE       = 16'h5A3C,   // Arbitrary value.
   parameter logic [15:0] TRANSPORT_CODE = 16'hC3A5    // Arbitrary value.
) (
   input  wire logic       sys_clk_in,           // 25 MHz clock
   input  wire logic       reset_n_in,           // Synchronous reset, active low
   input  wire logic       level_force_pin_in,   // High selects level one if fuse intact
   input  wire szac_req_s  req_in,               // Request: op, bit address, compare bit
   output logic            done_out,             // One-cycle answer pulse
   output logic            granted_out,          // Request was permitted
   output logic            rd_data_out,          // Read data, zero when refused
   output szac_stat_s      status_out            // Flags and level
);

   // Memory image: erased everywhere except the factory codes. The array is
   // not touched by reset because it stands for nonvolatile cells.
   localparam logic [MEM_BITS-1:0] MEM_INIT =
      {{(MEM_BITS - int'(SC_HI) - 1){1'b1}}, TRANSPORT_CODE,
       {(int'(SC_LO) - int'(FAB_HI) - 1){1'b1}}, FAB_CODE};

   logic [MEM_BITS-1:0] mem_q = MEM_INIT;
   logic [MEM_BITS-1:0] mem_d;
   logic [MEM_BITS-1:0] erase_mask;
   logic                sv_q;
   logic                ea_q;
   logic                eb_q;
   szac_cmp_e           cmp_q;
   logic [10:0]         cmp_next_q;
   logic                cmp_miss_q;
   logic                allow;
   logic                word_erase;
   logic                area_erase_a;
   logic                area_erase_b;
   logic                bump_counter;
   logic                iss_intact;
   logic                level2;
   logic                tally_locked;
   logic                sv_eff;
   logic                elim_on;
   logic                ec_spent;
   logic [127:0]        ec_vec;
   logic [10:0]         a;
   logic                modify;
   logic                bit_miss;
   logic                cmp_done_ok;

   function automatic logic in_zone(input logic [10:0] adr, input logic [10:0] lo,
                                    input logic [10:0] hi);
      in_zone = (adr >= lo) && (adr <= hi);
   endfunction

   function automatic logic [MEM_BITS-1:0] span_mask(input logic [10:0] lo,
                                                     input logic [10:0] hi);
      logic [MEM_BITS-1:0] m;
      m = '0;
      for (int i = 0; i < MEM_BITS; i++) begin
         m[i] = in_zone(ADDR_W'(i), lo, hi);
      end
      span_mask = m;
   endfunction

   assign a            = req_in.addr;
   assign modify       = (req_in.op == OP_WRITE) || (req_in.op == OP_ERASE);
   assign iss_intact   = &mem_q[ISSF_HI:ISSF_LO];
   assign level2       = !level_force_pin_in || !iss_intact;
   assign tally_locked = ~|mem_q[TALLY_ACT_HI:TALLY_LO];
   // A blocked tally makes every code-gated permission fail for good.
   assign sv_eff       = sv_q && !tally_locked;
   assign elim_on      = mem_q[ELIM_FUSE] && level2;
   assign ec_vec       = mem_q[EC_HI:EC_LO];
   assign ec_spent     = ~|ec_vec;

   // Access decision for the presented request.
   always_comb begin
      allow        = 1'b0;
      word_erase   = 1'b0;
      area_erase_a = 1'b0;
      area_erase_b = 1'b0;
      bump_counter = 1'b0;
      if (req_in.op == OP_COMPARE) begin
         allow = 1'b1;
      end else if (req_in.op == OP_READ) begin
         if (in_zone(a, SC_LO, SC_HI) || in_zone(a, KEYA_LO, KEYA_HI) ||
             in_zone(a, KEYB_LO, KEYB_HI)) begin
            allow = sv_eff;
         end else if (in_zone(a, APPA_LO, APPA_HI)) begin
            allow = sv_eff || mem_q[APPA_RLOCK];
         end else if (in_zone(a, APPB_LO, APPB_HI)) begin
            allow = sv_eff || mem_q[APPB_RLOCK];
         end else begin
            allow = 1'b1;
         end
      end else if (in_zone(a, FAB_LO, FAB_HI)) begin
         allow = 1'b0;
      end else if (in_zone(a, ISS_LO, ISS_HI)) begin
         allow      = iss_intact && sv_eff;
         word_erase = 1'b1;
      end else if (in_zone(a, SC_LO, SC_HI) || in_zone(a, CGA_LO, CGA_HI)) begin
         allow      = sv_eff;
         word_erase = 1'b1;
      end else if (in_zone(a, TALLY_LO, TALLY_HI)) begin
         // Counting an attempt must work before verification.
         if (req_in.op == OP_WRITE) begin
            allow = in_zone(a, TALLY_LO, TALLY_ACT_HI) || sv_eff;
         end else begin
            allow      = sv_eff;
            word_erase = 1'b1;
         end
      end else if (in_zone(a, APPA_LO, APPA_HI)) begin
         if (req_in.op == OP_WRITE) begin
            allow = sv_eff && (!level2 || mem_q[APPA_WLOCK]);
         end else if (!level2) begin
            allow      = sv_eff;
            word_erase = 1'b1;
         end else begin
            allow        = sv_eff && ea_q;
            area_erase_a = 1'b1;
         end
      end else if (in_zone(a, APPB_LO, APPB_HI)) begin
         if (req_in.op == OP_WRITE) begin
            allow = sv_eff && (!level2 || mem_q[APPB_WLOCK]);
         end else if (!level2) begin
            allow      = sv_eff;
            word_erase = 1'b1;
         end else begin
            allow        = sv_eff && eb_q && !(elim_on && ec_spent);
            area_erase_b = 1'b1;
            bump_counter = elim_on;
         end
      end else if (in_zone(a, KEYA_LO, KEYA_HI) || in_zone(a, KEYB_LO, KEYB_HI)) begin
         allow      = sv_eff && iss_intact;
         word_erase = 1'b1;
      end else if ((a == ELIM_FUSE) || in_zone(a, ISSF_LO, ISSF_HI)) begin
         // Fuses may be blown but never restored.
         allow = (req_in.op == OP_WRITE) && sv_eff && iss_intact;
      end else begin
         allow = 1'b0;
      end
   end

   // Erase span: aligned word, or the whole application area in level two.
   always_comb begin
      erase_mask = '0;
      if (area_erase_a) begin
         erase_mask = span_mask(APPA_LO, APPA_HI);
      end else if (area_erase_b) begin
         erase_mask = span_mask(APPB_LO, APPB_HI);
      end else if (word_erase) begin
         erase_mask = span_mask({a[10:WORD_LSB_W], WORD_FIRST},
                                {a[10:WORD_LSB_W], WORD_LAST});
      end
   end

   always_comb begin
      mem_d = mem_q;
      if (req_in.valid && allow && (req_in.op == OP_WRITE)) begin
         mem_d[a] = 1'b0;
      end else if (req_in.valid && allow && (req_in.op == OP_ERASE)) begin
         mem_d = mem_q | erase_mask;
         if (bump_counter) begin
            // Spending one counter cell per area B erase: clear the lowest set bit.
            mem_d[EC_HI:EC_LO] = ec_vec & (ec_vec - 128'h1);
         end
      end
   end

   // Nonvolatile cells ignore reset; denied requests leave them as they are.
   always_ff @(posedge sys_clk_in) begin
      mem_q <= mem_d;
   end

   // Bit-serial password comparison.
   assign bit_miss = req_in.cmp_bit != mem_q[a];

   always_comb begin
      cmp_done_ok = 1'b0;
      if (req_in.valid && (req_in.op == OP_COMPARE) && (cmp_q != CMP_IDLE) &&
          (a == cmp_next_q) && !cmp_miss_q && !bit_miss) begin
         case (cmp_q)
            CMP_SC:    cmp_done_ok = (a == SC_HI);
            CMP_KEY_A: cmp_done_ok = (a == KEYA_HI);
            CMP_KEY_B: cmp_done_ok = (a == KEYB_HI);
            default:   cmp_done_ok = 1'b0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         cmp_q      <= CMP_IDLE;
         cmp_next_q <= '0;
         cmp_miss_q <= 1'b0;
      end else if (req_in.valid && (req_in.op == OP_COMPARE)) begin
         cmp_next_q <= a + 11'h001;
         if (a == SC_LO) begin
            cmp_q      <= tally_locked ? CMP_IDLE : CMP_SC;
            cmp_miss_q <= bit_miss;
         end else if (a == KEYA_LO) begin
            cmp_q      <= CMP_KEY_A;
            cmp_miss_q <= bit_miss;
         end else if (a == KEYB_LO) begin
            cmp_q      <= CMP_KEY_B;
            cmp_miss_q <= bit_miss;
         end else if ((cmp_q != CMP_IDLE) && (a == cmp_next_q) &&
                      (a != SC_HI) && (a != KEYA_HI) && (a != KEYB_HI)) begin
            cmp_miss_q <= cmp_miss_q | bit_miss;
         end else begin
            // Last bit reached or the address sequence broke.
            cmp_q      <= CMP_IDLE;
            cmp_miss_q <= 1'b0;
         end
      end
   end

   // Verification flags; a failed compare never clears an earlier success.
   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         sv_q <= 1'b0;
         ea_q <= 1'b0;
         eb_q <= 1'b0;
      end else if (cmp_done_ok) begin
         if (cmp_q == CMP_SC) begin
            sv_q <= 1'b1;
         end
         if (cmp_q == CMP_KEY_A) begin
            ea_q <= 1'b1;
         end
         if (cmp_q == CMP_KEY_B) begin
            eb_q <= 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         done_out    <= 1'b0;
         granted_out <= 1'b0;
         rd_data_out <= 1'b0;
      end else begin
         done_out    <= req_in.valid;
         granted_out <= req_in.valid && allow;
         rd_data_out <= req_in.valid && allow && (req_in.op == OP_READ) && mem_q[a];
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (!reset_n_in) begin
         status_out <= '0;
      end else begin
         status_out.security_valid_flag <= sv_eff;
         status_out.app_a_erase_ok      <= ea_q;
         status_out.app_b_erase_ok      <= eb_q;
         status_out.level2              <= level2;
         status_out.tally_locked        <= tally_locked;
         status_out.erase_limit_spent   <= elim_on && ec_spent;
      end
   end

endmodule

// ---- szac_props.sv ----
// Checker for the secure zone access control block, watching only its ports.
// Assumes one clock domain and the synchronous active-low reset of the block.
`timescale 1ns/1ps
module szac_props
   import szac_pkg::*;
(
   input wire logic       sys_clk_in,          // Block clock
   input wire logic       reset_n_in,          // Synchronous reset, active low
   input wire logic       level_force_pin_in,  // Level pin
   input wire szac_req_s  req_in,              // Request
   input wire logic       done_out,            // Answer pulse
   input wire logic       granted_out,         // Permission
   input wire logic       rd_data_out,         // Read data
   input wire szac_stat_s status_out           // Flags and level
);
   default clocking cb @(posedge sys_clk_in);
   endclocking
   default disable iff (!reset_n_in);
   wire logic modify = req_in.valid && (req_in.op == OP_WRITE || req_in.op == OP_ERASE);
   wire logic rd_req = req_in.valid && req_in.op == OP_READ;

   a_done_follows: assert property (req_in.valid |=> done_out)
      else $error("no answer one cycle after a request");
   a_no_spurious: assert property (!req_in.valid |=> !done_out && !granted_out)
      else $error("answer without a request");
   a_refused_zero: assert property (!granted_out |-> !rd_data_out)
      else $error("read data shown on a refused request");
   a_fab_fixed: assert property (modify && req_in.addr <= FAB_HI |=> !granted_out)
      else $error("fabrication area modify granted");
   a_issuer_read: assert property (rd_req && req_in.addr inside {[ISS_LO:ISS_HI]}
      |=> granted_out)
      else $error("issuer area read refused");
   a_guard_read: assert property (rd_req && req_in.addr inside {[CGA_LO:CGA_HI]}
      |=> granted_out)
      else $error("code guarded area read refused");
   a_guard_modify: assert property (!req_in.valid ##1 (modify && !status_out.security_valid_flag
      && req_in.addr inside {[CGA_LO:CGA_HI]}) |=> !granted_out)
      else $error("code guarded area modified without verification");
   a_level_forced: assert property ((reset_n_in && !level_force_pin_in) [*3]
      |-> status_out.level2)
      else $error("level two not shown with the level pin low");
   a_sv_unlocked: assert property (status_out.security_valid_flag
      |-> !status_out.tally_locked)
      else $error("security valid while the tally is exhausted");
   a_reset_clear: assert property ($rose(reset_n_in) |-> status_out == '0 && !done_out)
      else $error("flags not cleared by reset");
   a_spent_level: assert property (status_out.erase_limit_spent |-> status_out.level2)
      else $error("erase limit spent outside level two");

   c_verified: cover property (status_out.security_valid_flag);
   c_key_a: cover property (status_out.app_a_erase_ok && status_out.level2);
   c_locked: cover property (status_out.tally_locked);
   c_modify: cover property (modify ##1 granted_out);
endmodule

bind szac_core szac_props u_props (.sys_clk_in(sys_clk_in), .reset_n_in(reset_n_in),
   .level_force_pin_in(level_force_pin_in), .req_in(req_in), .done_out(done_out),
   .granted_out(granted_out), .rd_data_out(rd_data_out), .status_out(status_out));

// ---- szac_reader.sv ----
// Card reader model that issues one request at a time to the access block.
// Assumes the bench calls issue from a falling clock edge and waits for it.
`timescale 1ns/1ps
module szac_reader
   import szac_pkg::*;
(
   input  wire logic sys_clk_in,   // Block clock
   input  wire logic done_in,      // Answer pulse
   input  wire logic granted_in,   // Permission
   input  wire logic rd_data_in,   // Read data
   output szac_req_s req_out       // Request to the block
);
   logic got_done;
   logic got_grant;
   logic got_rd;
   initial req_out = '0;
   // Idle fields are inverted so a stale address can never pass for a live one.
   task automatic issue(input szac_op_e op, input logic [10:0] a, input logic b);
      @(negedge sys_clk_in);
      req_out = '{1'b1, op, a, b};
      @(negedge sys_clk_in);
      got_done = done_in;
      got_grant = granted_in;
      got_rd = rd_data_in;
      req_out = '{1'b0, szac_op_e'(~op), ~a, ~b};
   endtask
endmodule

// ---- test_secure_zone_access_control.sv ----
// Self-checking bench for the access block, with a bit-level memory model.
// Assumes a 25 MHz clock and the reader model for all requests.
`timescale 1ns/1ps
module test_secure_zone_access_control
   import szac_pkg::*;
;
   logic       sys_clk_in = 1'b0;
   logic       reset_n_in = 1'b0;
   logic       pin        = 1'b1;
   logic       done, granted, rd;
   szac_req_s  req;
   szac_stat_s stat;
   int         fails = 0, tests_run = 0, cst = 0, nxt = 0;
   int         mem [MEM_BITS];
   bit         sv, ea, eb, cok;
   logic [15:0] lfsr = 16'h0038;
   always #20 sys_clk_in = ~sys_clk_in;
   // Symmetric codes keep the model independent of bit order within a word.
   szac_core #(.FAB_CODE(16'h0000), .TRANSPORT_CODE(16'hFFFF)) dut (.sys_clk_in(sys_clk_in),
      .reset_n_in(reset_n_in), .level_force_pin_in(pin), .req_in(req), .done_out(done),
      .granted_out(granted), .rd_data_out(rd), .status_out(stat));
   szac_reader rdr (.sys_clk_in(sys_clk_in), .done_in(done), .granted_in(granted),
      .rd_data_in(rd), .req_out(req));
   function automatic bit in_z(int a, int lo, int hi);
      return a >= lo && a <= hi;
   endfunction
   function automatic logic [15:0] lfsr_next(logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic int cnt0(int lo, int hi);
      int n;
      n = 0;
      for (int i = lo; i <= hi; i++)
         n += (mem[i] == 0);
      return n;
   endfunction
   function automatic bit l2();
      return !pin || cnt0(1552, 1567) != 0;
   endfunction
   task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic op(szac_op_e k, int a, logic b);
      bit g, s, w, ap, bp;
      s = sv && cnt0(96, 103) != 8;
      w = cnt0(1552, 1567) == 0;
      ap = in_z(a, 176, 687);
      bp = in_z(a, 736, 1247);
      case (k)
         OP_READ: g = (in_z(a, 80, 95) || in_z(a, 688, 735) || in_z(a, 1248, 1279)) ? s :
            ap ? (s || mem[177]) : bp ? (s || mem[737]) : 1'b1;
         OP_WRITE: g = in_z(a, 96, 103) || (s && (in_z(a, 80, 95) || in_z(a, 104, 175) ||
            (ap && (!l2() || mem[176])) || (bp && (!l2() || mem[736])) || (w && (in_z(a, 16, 79)
            || in_z(a, 688, 735) || in_z(a, 1248, 1279) || a == 1529 || in_z(a, 1552, 1567)))));
         OP_ERASE: g = s && (in_z(a, 80, 175) || (w && (in_z(a, 16, 79) || in_z(a, 688, 735) ||
            in_z(a, 1248, 1279))) || ((ap || bp) && !l2())
            || (ap && ea) || (bp && eb && (!mem[1529] || cnt0(1280, 1407) != 128)));
         default: g = 1'b0;
      endcase
      rdr.issue(k, a[10:0], b);
      check("done", rdr.got_done, 1);
      if (k != OP_COMPARE) begin
         check("granted", rdr.got_grant, g);
         check("read data", rdr.got_rd, (k == OP_READ && g) ? mem[a][0] : 1'b0);
      end
      if (g && k == OP_WRITE)
         mem[a] = 0;
      if (g && k == OP_ERASE && (ap || bp) && l2()) begin
         for (int i = 0; i < 512; i++)
            mem[(ap ? 176 : 736) + i] = 1;
         for (int i = 1280; i <= 1407 && bp && mem[1529] == 1; i++)
            if (mem[i] == 1) begin
               mem[i] = 0;
               break;
            end
      end else if (g && k == OP_ERASE)
         for (int i = 0; i < 16; i++)
            mem[(a & ~15) + i] = 1;
      if (k == OP_COMPARE) begin
         if (cst != 0 && a == nxt)
            cok = cok && (b == mem[a]);
         else begin
            cst = (a == 80 && cnt0(96, 103) != 8) ? 1 : a == 688 ? 2 : a == 1248 ? 3 : 0;
            cok = (b == mem[a]);
         end
         nxt = a + 1;
         sv |= cok && cst == 1 && a == 95;
         ea |= cok && cst == 2 && a == 735;
         eb |= cok && cst == 3 && a == 1279;
      end
   endtask
   task automatic run(logic [12:0] steps []);
      foreach (steps[i])
         op(szac_op_e'(steps[i][12:11]), steps[i][10:0], 1'b0);
   endtask
   task automatic chk_status();
      repeat (2) @(negedge sys_clk_in);
      check("status", stat, {sv && cnt0(96, 103) != 8, ea, eb, l2(), cnt0(96, 103) == 8,
         l2() && mem[1529] == 1 && cnt0(1280, 1407) == 128});
   endtask
   task automatic present(logic [15:0] code, int tbit);
      op(OP_WRITE, tbit, 1'b0);
      for (int i = 0; i < 16; i++)
         op(OP_COMPARE, 80 + i, code[i]);
      op(OP_ERASE, 100, 1'b0);
   endtask
   task automatic key(int lo, int hi);
      for (int a = lo; a <= hi; a++)
         op(OP_COMPARE, a, mem[a][0]);
   endtask
   task automatic do_reset(int n);
      reset_n_in = 1'b0;
      repeat (n) @(negedge sys_clk_in);
      reset_n_in = 1'b1;
      {sv, ea, eb} = 3'h0;
      cst = 0;
   endtask
   task automatic finish_test();
      if (fails == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   initial begin
      #(40 * 20000);
      fails++;
      finish_test();
   end
   initial begin
      for (int i = 0; i < MEM_BITS; i++)
         mem[i] = (i <= 15) ? 0 : 1;
      do_reset(16);
      chk_status();
      run('{{OP_READ, 11'h014}, {OP_READ, 11'h078}, {OP_READ, 11'h055}, {OP_WRITE, 11'h078},
         {OP_WRITE, 11'h0C8}, {OP_READ, 11'h0C8}});
      present(16'hFFFF, 96);
      chk_status();
      run('{{OP_WRITE, 11'h003}, {OP_READ, 11'h003}, {OP_WRITE, 11'h014}, {OP_READ, 11'h014},
         {OP_WRITE, 11'h055}, {OP_READ, 11'h055}, {OP_ERASE, 11'h055}, {OP_WRITE, 11'h078},
         {OP_ERASE, 11'h079}, {OP_READ, 11'h078}, {OP_WRITE, 11'h0C8}, {OP_WRITE, 11'h0D2},
         {OP_ERASE, 11'h0C8}, {OP_READ, 11'h0C8}, {OP_READ, 11'h0D2}, {OP_WRITE, 11'h2BC},
         {OP_WRITE, 11'h4E2}, {OP_ERASE, 11'h4E2}});
      repeat (16) begin
         lfsr = lfsr_next(lfsr);
         op(szac_op_e'(lfsr[1:0] % 3), 178 + lfsr[15:2] % 510, lfsr[2]);
      end
      pin = 1'b0;
      chk_status();
      run('{{OP_WRITE, 11'h12C}, {OP_ERASE, 11'h12C}});
      key(688, 735);
      chk_status();
      run('{{OP_ERASE, 11'h12C}, {OP_READ, 11'h12C}, {OP_READ, 11'h258}});
      key(1248, 1279);
      // One erase past the counter's capacity must be refused.
      repeat (129) run('{{OP_ERASE, 11'h320}});
      chk_status();
      run('{{OP_WRITE, 11'h0B0}, {OP_WRITE, 11'h190}, {OP_WRITE, 11'h2E0}, {OP_WRITE, 11'h320},
         {OP_WRITE, 11'h0B1}});
      do_reset(2);
      chk_status();
      run('{{OP_READ, 11'h190}, {OP_READ, 11'h320}});
      pin = 1'b1;
      present(16'hFFFF, 97);
      run('{{OP_WRITE, 11'h610}, {OP_WRITE, 11'h01E}, {OP_ERASE, 11'h01E}, {OP_READ, 11'h01E},
         {OP_WRITE, 11'h2BE}, {OP_WRITE, 11'h4E4}});
      chk_status();
      do_reset(2);
      for (int i = 0; i < 8; i++)
         present(16'h0000, 96 + i);
      present(16'hFFFF, 96);
      chk_status();
      run('{{OP_WRITE, 11'h078}, {OP_WRITE, 11'h190}, {OP_READ, 11'h055}});
      finish_test();
   end
endmodule
